// [rtl/parallel_io_unit.sv]
// dual 8-bit parallel port with ready/strobe handshake
// Functional notes
// - two 8-bit ports, each with ready and strobe
// - four modes, bidirectional only on port A
// - output byte moves from fifo to lines and raises ready on the same clock edge
// - strobe pulse clears ready, requests interrupt
// - input strobe latches byte, drops ready, interrupts
// - ready returns after processor reads latched byte
// - port A bidirectional uses all four handshake lines
// - bit mode direction set per line by mask
// - bit mode inputs interrupt on chosen edge
// - bit interrupt from unmasked input lines, AND or OR
// - requests come from edges, not held levels
// - direction byte follows mode word in bit mode
// - each port holds a programmable vector byte
// - disable word sets enable from bit 7, keeps other settings
// - registers decode at 40h to 43h
`timescale 1ns/100ps
`default_nettype none
module parallel_io_unit import pio_pkg::*; #(
  parameter int FIFO_WORDS = FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // processor i/o bus
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_wait,
  // port a lines
  input wire logic [7:0] port_a_lines_in,
  output logic [7:0] port_a_lines_out,
  output logic [7:0] port_a_lines_oe,
  // port b lines
  input wire logic [7:0] port_b_lines_in,
  output logic [7:0] port_b_lines_out,
  output logic [7:0] port_b_lines_oe,
  // handshake lines
  output logic port_a_ready,
  input wire logic port_a_strobe_n,
  output logic port_b_ready,
  input wire logic port_b_strobe_n,
  // interrupt requests and vectors
  output logic port_a_int_req,
  output logic port_b_int_req,
  output logic [7:0] port_a_vector,
  output logic [7:0] port_b_vector
);
  localparam int NPORT = 2;

  // the fifo sizing must be servable by the fifo module
  initial begin
    if (FIFO_WORDS < 2 || (1 << $clog2(FIFO_WORDS)) != FIFO_WORDS) begin
      $error("parallel_io_unit: fifo depth must be a power of two");
    end
  end

  // register address match, used for data and command of each port
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  // per-port views of the pins
  logic [7:0] lines_in [0:NPORT-1]; // line levels straight from the pins
  logic strobe_n [0:NPORT-1]; // strobe pins, active low
  logic [7:0] out_q [0:NPORT-1]; // output holding register
  logic [7:0] oe_w [0:NPORT-1]; // per-line drive enable
  logic ready_w [0:NPORT-1]; // ready pin values
  logic [7:0] rdval_w [0:NPORT-1]; // data register read value
  logic irq_q [0:NPORT-1]; // one-cycle interrupt request
  logic [7:0] vec_w [0:NPORT-1]; // programmed vectors
  logic stb_q [0:NPORT-1]; // strobe one cycle ago
  logic stb_rise [0:NPORT-1]; // end of a low strobe pulse
  logic data_wr [0:NPORT-1]; // data register write request
  logic data_rd [0:NPORT-1]; // data register read
  logic cmd_wr [0:NPORT-1]; // command register write
  logic wr_ready [0:NPORT-1]; // fifo can take a byte
  logic ordy_q [0:NPORT-1]; // output side ready state
  logic irdy_q [0:NPORT-1]; // input side ready state
  logic a_bidir; // port a has taken port b's handshake

  assign lines_in[0] = port_a_lines_in;
  assign lines_in[1] = port_b_lines_in;
  assign strobe_n[0] = port_a_strobe_n;
  assign strobe_n[1] = port_b_strobe_n;

  // address decode
  wire hit_a_data = addr_hit(io_addr, ADDR_A_DATA);
  wire hit_a_cmd = addr_hit(io_addr, ADDR_A_CMD);
  wire hit_b_data = addr_hit(io_addr, ADDR_B_DATA);
  wire hit_b_cmd = addr_hit(io_addr, ADDR_B_CMD);
  assign data_wr[0] = io_wr & hit_a_data;
  assign data_wr[1] = io_wr & hit_b_data;
  assign data_rd[0] = io_rd & hit_a_data;
  assign data_rd[1] = io_rd & hit_b_data;
  assign cmd_wr[0] = io_wr & hit_a_cmd;
  assign cmd_wr[1] = io_wr & hit_b_cmd;

  // a data write into a full fifo stalls the processor bus cycle
  assign io_wait = (data_wr[0] & ~wr_ready[0]) | (data_wr[1] & ~wr_ready[1]);

  // read mux; command registers are write-only and read as zero
  wire [7:0] rd_sel = hit_a_data ? rdval_w[0] : hit_b_data ? rdval_w[1] : BYTE_ZERO;

  // registered read data, valid the cycle after the read
  logic [7:0] rdata_q;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdata_q <= BYTE_ZERO;
    end else if (io_rd) begin
      rdata_q <= rd_sel;
    end
  end
  assign io_rdata = rdata_q;

  // one block of logic per port
  for (genvar i = 0; i < NPORT; i++) begin : g_port
    logic [1:0] mode; // current operating mode
    logic mode_wr; // mode word just taken
    logic [7:0] dir; // 1 = input line in bit mode
    logic ie; // port interrupt enable
    logic use_and; // all selected lines must be active
    logic use_high; // rising edge is the active edge
    logic [7:0] mask; // 1 = line ignored for interrupts
    logic f_valid; // fifo holds a byte to send
    logic [7:0] f_data; // oldest byte in fifo
    logic [7:0] in_q; // latched input byte
    logic match_q; // bit-mode condition last cycle

    // command sequencer
    port_command #(
      .ALLOW_BIDIR(i == 0),
      .VEC_RESET((i == 0) ? VEC_A_RESET : VEC_B_RESET)
    ) u_cmd (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .wr(cmd_wr[i]),
      .wdata(io_wdata),
      .mode_q(mode),
      .mode_wr(mode_wr),
      .dir_q(dir),
      .vector_q(vec_w[i]),
      .ie_q(ie),
      .and_q(use_and),
      .high_q(use_high),
      .mask_q(mask)
    );

    // mode decode
    wire m_out = (mode == MODE_OUT);
    wire m_in = (mode == MODE_IN);
    wire m_bi = (mode == MODE_BIDIR);
    wire m_bit = (mode == MODE_BIT);

    // port b loses its handshake while port a is bidirectional
    wire taken = (i == 1) && a_bidir;

    // strobe events are edges, so a held strobe acts once
    assign stb_rise[i] = strobe_n[i] & ~stb_q[i];

    // acknowledge of an output byte on this port's own strobe
    wire out_ack = (m_out | m_bi) & stb_rise[i] & ordy_q[i] & ~taken;

    // input latch strobe: own strobe, or port b's in bidirectional
    wire in_rise = (m_in & stb_rise[i] & ~taken) | ((i == 0) && m_bi && stb_rise[1]);

    // move the next byte out once the peripheral has taken the last
    wire pop = f_valid & (m_bit | m_in | ~ordy_q[i]);

    // processor read of the latched byte frees the input side
    wire read_ack = data_rd[i] & (m_in | m_bi);

    // bit-mode condition over selected input lines
    wire [7:0] active = use_high ? lines_in[i] : ~lines_in[i];
    wire [7:0] sel = dir & ~mask;
    wire all_hit = (&(active | ~sel)) & (|sel);
    wire any_hit = |(active & sel);
    wire match = m_bit & (use_and ? all_hit : any_hit);
    // chosen edge of the condition requests once
    wire bit_event = match & ~match_q;

    wire irq_d = ie & (out_ack | in_rise | bit_event);

    // writes queue in the fifo ahead of the output register
    byte_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_WORDS)
    ) u_fifo (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .in_valid(data_wr[i]),
      .in_ready(wr_ready[i]),
      .in_data(io_wdata),
      .out_valid(f_valid),
      .out_ready(pop),
      .out_data(f_data)
    );

    // strobe history and bit-mode condition history
    always_ff @(posedge ref_clk) begin
      if (!rstn) begin
        stb_q[i] <= 1'b1;
        match_q <= 1'b0;
      end else begin
        stb_q[i] <= strobe_n[i];
        match_q <= match;
      end
    end

    // output register and output-side ready
    always_ff @(posedge ref_clk) begin
      if (!rstn) begin
        out_q[i] <= BYTE_ZERO;
        ordy_q[i] <= 1'b0;
      end else begin
        if (pop) begin
          out_q[i] <= f_data;
        end
        if (mode_wr) begin
          ordy_q[i] <= 1'b0;
        end else if (out_ack) begin
          ordy_q[i] <= 1'b0;
        end else if (pop & (m_out | m_bi)) begin
          ordy_q[i] <= 1'b1;
        end
      end
    end

    // input latch and input-side ready; a new strobe beats a read
    always_ff @(posedge ref_clk) begin
      if (!rstn) begin
        in_q <= BYTE_ZERO;
        irdy_q[i] <= 1'b1;
      end else begin
        if (in_rise) begin
          in_q <= lines_in[i];
        end
        if (mode_wr) begin
          irdy_q[i] <= 1'b1;
        end else if (in_rise) begin
          irdy_q[i] <= 1'b0;
        end else if (read_ack) begin
          irdy_q[i] <= 1'b1;
        end
      end
    end

    // interrupt request pulse, gated by the port enable
    always_ff @(posedge ref_clk) begin
      if (!rstn) begin
        irq_q[i] <= 1'b0;
      end else begin
        irq_q[i] <= irq_d;
      end
    end

    // line drive: all in output mode, during strobe in bidirectional,
    // per direction mask in bit mode
    assign oe_w[i] = m_out ? BYTE_ONES :
                     m_bi ? {8{~strobe_n[i]}} :
                     m_bit ? ~dir : BYTE_ZERO;

    // own ready pin value; bit mode holds ready low
    assign ready_w[i] = m_in ? irdy_q[i] : (m_out | m_bi) ? ordy_q[i] : 1'b0;

    // data register read value per mode
    assign rdval_w[i] = m_bit ? ((lines_in[i] & dir) | (out_q[i] & ~dir)) :
                        (m_in | m_bi) ? in_q : out_q[i];
  end

  // port a bidirectional steers port b's ready pin
  assign a_bidir = (g_port[0].mode == MODE_BIDIR);

  // pin outputs
  assign port_a_lines_out = out_q[0];
  assign port_b_lines_out = out_q[1];
  assign port_a_lines_oe = oe_w[0];
  assign port_b_lines_oe = oe_w[1];
  assign port_a_ready = ready_w[0];
  assign port_b_ready = a_bidir ? irdy_q[0] : ready_w[1];

  // interrupt outputs
  assign port_a_int_req = irq_q[0];
  assign port_b_int_req = irq_q[1];
  assign port_a_vector = vec_w[0];
  assign port_b_vector = vec_w[1];
endmodule
`default_nettype wire

// [include/pio_pkg.sv]
// shared constants and types for the dual parallel port
package pio_pkg;
  // register decode addresses
  localparam logic [7:0] ADDR_A_DATA = 8'h40;
  localparam logic [7:0] ADDR_A_CMD = 8'h41;
  localparam logic [7:0] ADDR_B_DATA = 8'h42;
  localparam logic [7:0] ADDR_B_CMD = 8'h43;
  // operating modes, as held in the top two bits of the mode word
  localparam logic [1:0] MODE_OUT = 2'h0;
  localparam logic [1:0] MODE_IN = 2'h1;
  localparam logic [1:0] MODE_BIDIR = 2'h2;
  localparam logic [1:0] MODE_BIT = 2'h3;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  // command byte recognition by low-order pattern
  localparam logic [3:0] PAT_MODE = 4'hf;
  localparam logic [3:0] PAT_INTCTL = 4'h7;
  localparam logic [3:0] PAT_INTDIS = 4'h3;
  localparam logic [1:0] PAT_INTDIS_LO = 2'h3;
  // interrupt control word fields
  localparam int BIT_IE = 7;
  localparam int BIT_AND = 6;
  localparam int BIT_HIGH = 5;
  localparam int BIT_MASK_FOLLOWS = 4;
  localparam int BIT_VEC_FLAG = 0;
  // reset values
  localparam logic [1:0] MODE_RESET = 2'h1;
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] MASK_RESET = 8'hff;
  localparam logic [7:0] VEC_A_RESET = 8'h12;
  localparam logic [7:0] VEC_B_RESET = 8'h14;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  // fifo geometry
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
  // what the command register expects next
  typedef enum logic [1:0] {EXP_CMD, EXP_DIR, EXP_MASK} expect_t;
endpackage

// [rtl/byte_fifo.sv]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module byte_fifo import pio_pkg::*; #(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // pointer wrap relies on a power-of-two depth
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("byte_fifo: depth must be a power of two, at least 2");
    end
  end
  logic [WIDTH-1:0] mem [0:DEPTH-1]; // storage words
  logic [AW-1:0] wptr_q; // next write slot
  logic [AW-1:0] rptr_q; // next read slot
  logic [AW:0] count_q; // words held
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != '0);
  assign out_data = mem[rptr_q];
  // storage has no reset, only pointers and fill count need one
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wptr_q] <= in_data;
    end
  end
  // pointers and fill count
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
    end else begin
      wptr_q <= push ? wptr_q + 1'b1 : wptr_q;
      rptr_q <= pop ? rptr_q + 1'b1 : rptr_q;
      count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule
`default_nettype wire

// [rtl/port_command.sv]
// command register sequencer for one port
`timescale 1ns/100ps
`default_nettype none
module port_command import pio_pkg::*; #(
  parameter bit ALLOW_BIDIR = 1'b1,
  parameter logic [7:0] VEC_RESET = VEC_A_RESET
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // command byte write
  input wire logic wr,
  input wire logic [7:0] wdata,
  // configuration held
  output logic [1:0] mode_q,
  output logic mode_wr,
  output logic [7:0] dir_q,
  output logic [7:0] vector_q,
  output logic ie_q,
  output logic and_q,
  output logic high_q,
  output logic [7:0] mask_q
);
  expect_t exp_q; // which byte comes next
  wire [1:0] new_mode = wdata[MODE_HI:MODE_LO];
  wire is_seq = wr & (exp_q == EXP_CMD);
  wire is_mode = is_seq & (wdata[3:0] == PAT_MODE);
  wire is_vec = is_seq & ~wdata[BIT_VEC_FLAG];
  wire is_ictl = is_seq & (wdata[3:0] == PAT_INTCTL);
  wire is_idis = is_seq & (wdata[3:0] == PAT_INTDIS);
  // a bidirectional request on a port without it keeps the old mode
  wire mode_ok = ALLOW_BIDIR || (new_mode != MODE_BIDIR);
  assign mode_wr = is_mode & mode_ok;
  // sequencer and configuration fields
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      exp_q <= EXP_CMD;
      mode_q <= MODE_RESET;
      dir_q <= DIR_RESET;
      vector_q <= VEC_RESET;
      ie_q <= 1'b0;
      and_q <= 1'b0;
      high_q <= 1'b0;
      mask_q <= MASK_RESET;
    end else begin
      case (exp_q)
        EXP_DIR: if (wr) begin
          dir_q <= wdata;
          exp_q <= EXP_CMD;
        end
        EXP_MASK: if (wr) begin
          mask_q <= wdata;
          exp_q <= EXP_CMD;
        end
        default: begin
          if (mode_wr) begin
            mode_q <= new_mode;
            // direction byte only after bit mode
            exp_q <= (new_mode == MODE_BIT) ? EXP_DIR : EXP_CMD;
          end
          if (is_vec) begin
            vector_q <= wdata;
          end
          if (is_ictl) begin
            ie_q <= wdata[BIT_IE];
            and_q <= wdata[BIT_AND];
            high_q <= wdata[BIT_HIGH];
            exp_q <= wdata[BIT_MASK_FOLLOWS] ? EXP_MASK : EXP_CMD;
          end
          if (is_idis) begin
            ie_q <= wdata[BIT_IE]; // only the enable changes
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [verif/pio_properties.sv]
// checker of register bus and handshake properties of the parallel port
`timescale 1ns/100ps
`default_nettype none
module pio_checker import pio_pkg::*; #(
  parameter int FIFO_WORDS = FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // processor bus
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic io_wait,
  // handshake and interrupts
  input wire logic port_a_ready,
  input wire logic port_a_strobe_n,
  input wire logic port_b_ready,
  input wire logic port_b_strobe_n,
  input wire logic port_a_int_req,
  input wire logic port_b_int_req,
  input wire logic [7:0] port_a_vector,
  input wire logic [7:0] port_b_vector
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // address classes
  wire unmapped = (io_addr < ADDR_A_DATA) || (io_addr > ADDR_B_CMD);
  wire cmd_addr = (io_addr == ADDR_A_CMD) || (io_addr == ADDR_B_CMD);
  wire data_addr = (io_addr == ADDR_A_DATA) || (io_addr == ADDR_B_DATA);

  chk_vector_reset_values: assert property (
    $rose(rstn) |-> port_a_vector == 8'h12 && port_b_vector == 8'h14)
    else $error("vector not at reset value");
  chk_unmapped_read_zero: assert property (
    io_rd && unmapped |=> io_rdata == 8'h00) else $error("unmapped read not zero");
  chk_command_read_zero: assert property (
    io_rd && cmd_addr |=> io_rdata == 8'h00) else $error("command read not zero");
  chk_wait_cause: assert property (
    io_wait |-> io_wr && data_addr) else $error("wait without data write");
  chk_rdata_hold: assert property (
    !io_rd |=> $stable(io_rdata)) else $error("read data moved without read");
  chk_a_strobe_clears: assert property (
    $rose(port_a_strobe_n) && port_a_ready |=> !port_a_ready)
    else $error("port a ready not cleared by strobe");
  chk_b_strobe_clears: assert property (
    $rose(port_b_strobe_n) && port_b_ready |=> !port_b_ready)
    else $error("port b ready not cleared by strobe");
  chk_a_pulse_single: assert property (
    port_a_int_req |=> !port_a_int_req) else $error("port a request too long");
  chk_b_pulse_single: assert property (
    port_b_int_req |=> !port_b_int_req) else $error("port b request too long");
  // main scenarios reached
  cover property (io_wait);
  cover property (port_a_int_req);
  cover property ($fell(port_b_ready));
endmodule

bind parallel_io_unit pio_checker #(.FIFO_WORDS(FIFO_WORDS)) u_chk (
  .ref_clk(ref_clk), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
  .io_rdata(io_rdata), .io_wait(io_wait), .port_a_ready(port_a_ready),
  .port_a_strobe_n(port_a_strobe_n), .port_b_ready(port_b_ready),
  .port_b_strobe_n(port_b_strobe_n), .port_a_int_req(port_a_int_req),
  .port_b_int_req(port_b_int_req), .port_a_vector(port_a_vector),
  .port_b_vector(port_b_vector));
`default_nettype wire

// [verif/periph_model.sv]
// behavioural peripheral on one port's ready/strobe handshake
`timescale 1ns/100ps
`default_nettype none
module periph_model (
  // clock
  input wire logic ref_clk,
  // port side
  input wire logic ready,
  input wire logic [7:0] lines_out,
  output logic strobe_n,
  output logic [7:0] lines_in,
  // bench controls
  input wire logic ack_en,
  input wire logic send,
  input wire logic [7:0] send_byte,
  input wire logic hold_en,
  input wire logic [7:0] hold_val
);
  logic [7:0] drv_q = 8'h00; // last byte put on the lines
  logic [7:0] got[$]; // bytes taken from the port
  int busy = 0; // cycles left in the current strobe
  logic stb_n_q = 1'b1; // strobe level, idle high so no false edge
  assign strobe_n = stb_n_q;
  // released lines show the inverse of the last byte, never a stale copy
  assign lines_in = hold_en ? hold_val : drv_q;
  // one strobe at a time; the idle tail lets ready fall before looking again
  always @(posedge ref_clk) begin
    if (busy != 0) busy <= busy - 1;
    if (busy == 3) stb_n_q <= 1'b1; // end of pulse
    if (busy == 1) drv_q <= ~drv_q; // hold time over
    if (busy == 0 && send) begin
      drv_q <= send_byte;
      stb_n_q <= 1'b0;
      busy <= 5;
    end else if (busy == 0 && ack_en && ready) begin
      got.push_back(lines_out);
      stb_n_q <= 1'b0;
      busy <= 5;
    end
  end
endmodule
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the dual parallel port
`timescale 1ns/100ps
`default_nettype none
module tb import pio_pkg::*;;
  // clock, reset and processor bus
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] io_addr = 8'h00;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, a_vec, b_vec, v;
  logic io_wait, a_rdy, a_stb_n, b_rdy, b_stb_n, a_irq, b_irq;
  // partner controls
  logic a_ack = 1'b0;
  logic b_send = 1'b0;
  logic b_hold = 1'b0;
  logic [7:0] s_byte = 8'h00;
  logic [7:0] h_val = 8'h00;
  // bench state and reference queue
  int failures = 0;
  int comparisons = 0;
  int ia = 0;
  int ib = 0;
  int n;
  logic [31:0] seed = 32'd48;
  logic [7:0] exp_q[$];

  parallel_io_unit #(.FIFO_WORDS(FIFO_DEPTH)) u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_wait(io_wait),
    .port_a_lines_in(pa_in), .port_a_lines_out(pa_out), .port_a_lines_oe(pa_oe),
    .port_b_lines_in(pb_in), .port_b_lines_out(pb_out), .port_b_lines_oe(pb_oe),
    .port_a_ready(a_rdy), .port_a_strobe_n(a_stb_n), .port_b_ready(b_rdy),
    .port_b_strobe_n(b_stb_n), .port_a_int_req(a_irq), .port_b_int_req(b_irq),
    .port_a_vector(a_vec), .port_b_vector(b_vec));
  periph_model u_pa (.ref_clk(ref_clk), .ready(a_rdy), .lines_out(pa_out),
    .strobe_n(a_stb_n), .lines_in(pa_in), .ack_en(a_ack), .send(1'b0),
    .send_byte(8'h00), .hold_en(1'b0), .hold_val(8'h00));
  periph_model u_pb (.ref_clk(ref_clk), .ready(b_rdy), .lines_out(pb_out),
    .strobe_n(b_stb_n), .lines_in(pb_in), .ack_en(1'b0), .send(b_send),
    .send_byte(s_byte), .hold_en(b_hold), .hold_val(h_val));

  // clock
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  // interrupt pulses counted per port
  always @(posedge ref_clk) begin
    if (a_irq === 1'b1) ia++;
    if (b_irq === 1'b1) ib++;
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // write held until the fifo takes it; io_wait looked at once it settles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int k;
    @(negedge ref_clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    k = 0;
    #1;
    while (io_wait === 1'b1 && k < 300) begin
      @(negedge ref_clk);
      #1;
      k++;
    end
    @(negedge ref_clk);
    io_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge ref_clk);
    io_rd = 1'b0;
    d = io_rdata;
  endtask
  task automatic print_verdict();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    print_verdict();
  end

  initial begin
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
    rd(ADDR_A_CMD, v);
    chk8(v, 8'h00);
    rd(8'h7e, v);
    chk8(v, 8'h00);
    chk8(a_vec, 8'h12);
    chk8(b_vec, 8'h14);
    chk8({7'h00, a_rdy & b_rdy}, 8'h01);
    $display("test reset done");
    // port a output, partner stalled until the fifo refuses
    wr(ADDR_A_CMD, 8'h0f);
    wr(ADDR_A_CMD, 8'h20);
    wr(ADDR_A_CMD, 8'h87);
    chk8(a_vec, 8'h20);
    chk8(pa_oe, 8'hff);
    for (int i = 0; i < 10; i++) exp_q.push_back(rnd());
    for (int i = 0; i < 9; i++) wr(ADDR_A_DATA, exp_q[i]);
    fork
      wr(ADDR_A_DATA, exp_q[9]);
      begin
        repeat (6) @(negedge ref_clk);
        chk8({7'h00, io_wait}, 8'h01);
        a_ack = 1'b1;
      end
    join
    n = 0;
    while (u_pa.got.size() < 10 && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (8) @(negedge ref_clk);
    for (int i = 0; i < 10; i++) chk8(u_pa.got[i], exp_q[i]);
    chk8(8'(ia), 8'd10);
    rd(ADDR_A_DATA, v);
    chk8(v, exp_q[9]);
    // interrupt disabled then enabled again
    wr(ADDR_A_CMD, 8'h03);
    wr(ADDR_A_DATA, 8'h3c);
    repeat (16) @(negedge ref_clk);
    chk8(8'(ia), 8'd10);
    wr(ADDR_A_CMD, 8'h83);
    wr(ADDR_A_DATA, 8'hc3);
    repeat (16) @(negedge ref_clk);
    chk8(8'(ia), 8'd11);
    chk8(u_pa.got[11], 8'hc3);
    chk8(a_vec, 8'h20);
    $display("test output done");
    // port b strobed input
    wr(ADDR_B_CMD, 8'h4f);
    wr(ADDR_B_CMD, 8'h87);
    for (int i = 0; i < 3; i++) begin
      s_byte = rnd();
      b_send = 1'b1;
      @(negedge ref_clk);
      b_send = 1'b0;
      repeat (9) @(negedge ref_clk);
      chk8({7'h00, b_rdy}, 8'h00);
      rd(ADDR_B_DATA, v);
      chk8(v, s_byte);
      chk8({7'h00, b_rdy}, 8'h01);
    end
    chk8(8'(ib), 8'd3);
    $display("test input done");
    // port b bitwise, upper nibble inputs, or then and of rising lines
    b_hold = 1'b1;
    wr(ADDR_B_CMD, 8'hcf);
    wr(ADDR_B_CMD, 8'hf0);
    wr(ADDR_B_CMD, 8'h16);
    wr(ADDR_B_CMD, 8'hb7);
    wr(ADDR_B_CMD, 8'h0f);
    chk8(pb_oe, 8'h0f);
    chk8(b_vec, 8'h16);
    wr(ADDR_B_DATA, 8'h5a);
    repeat (3) @(negedge ref_clk);
    chk8(pb_out & pb_oe, 8'h0a);
    h_val = 8'h01;
    repeat (6) @(negedge ref_clk);
    chk8(8'(ib), 8'd3);
    h_val = 8'h10;
    repeat (12) @(negedge ref_clk);
    chk8(8'(ib), 8'd4);
    h_val = 8'h30;
    repeat (6) @(negedge ref_clk);
    chk8(8'(ib), 8'd4);
    rd(ADDR_B_DATA, v);
    chk8(v, 8'h3a);
    wr(ADDR_B_CMD, 8'hf7);
    wr(ADDR_B_CMD, 8'h0f);
    h_val = 8'hf0;
    repeat (6) @(negedge ref_clk);
    chk8(8'(ib), 8'd5);
    $display("test bitwise done");
    // bidirectional taken on port a only
    a_ack = 1'b0;
    wr(ADDR_B_CMD, 8'h8f);
    chk8(pb_oe, 8'h0f);
    wr(ADDR_A_CMD, 8'h8f);
    chk8(pa_oe, 8'h00);
    $display("test bidir done");
    print_verdict();
  end
endmodule
`default_nettype wire
